// *** core/isum_pkg.sv ***
/*
 * shared constants of the interrupt summary and serial line block:
 * register indices, field positions, reset values and priority levels.
 * assumes a 64-bit classic wishbone slave port, one word per register.
 */
package isum_pkg;

   // ==========================================================
   // bus geometry
   localparam int DW     = 64;
   localparam int SW     = 8;
   localparam int AW     = 12;
   localparam int IDX_LO = 3;
   localparam int IDX_HI = 11;
   localparam int IW     = 9;

   // ==========================================================
   // register indices, byte address is index times eight
   localparam logic [IW-1:0] IDX_SUMMARY  = 9'h100;
   localparam logic [IW-1:0] IDX_SOFTWARE_INTERRUPT_REQUEST     = 9'h108;
   localparam logic [IW-1:0] IDX_TRAP_REQ = 9'h109;
   localparam logic [IW-1:0] IDX_TRAP_EN  = 9'h10A;
   localparam logic [IW-1:0] IDX_IUCTL    = 9'h10D;
   localparam logic [IW-1:0] IDX_IPL      = 9'h110;
   localparam logic [IW-1:0] IDX_HWCLR    = 9'h115;
   localparam logic [IW-1:0] IDX_XMIT     = 9'h116;
   localparam logic [IW-1:0] IDX_RCV      = 9'h117;
   localparam logic [IW-1:0] IDX_PERF     = 9'h11C;

   // ==========================================================
   // field positions
   localparam int TRAP_HI   = 3;
   localparam int SWR_HI    = 18;
   localparam int SWR_LO    = 4;
   localparam int TRAP_PEND = 19;
   localparam int EXT_LO    = 20;
   localparam int EXT_HI    = 23;
   localparam int PERF_LO   = 27;
   localparam int PERF_HI   = 29;
   localparam int PFL_BIT   = 30;
   localparam int MCK_BIT   = 31;
   localparam int CRD_BIT   = 32;
   localparam int SLI_BIT   = 33;
   localparam int HLT_BIT   = 34;
   localparam int SUM_HI    = 34;
   localparam int SLE_BIT   = 33;
   localparam int IPL_HI    = 4;
   localparam int TMT_BIT   = 7;
   localparam int RCV_BIT   = 6;
   localparam int COUNTER2_SELECT_LO   = 0;
   localparam int COUNTER2_SELECT_HI   = 3;
   localparam int COUNTER1_SELECT_LO   = 4;
   localparam int COUNTER1_SELECT_HI   = 7;

   // ==========================================================
   // reset values and encodings
   localparam logic            TMT_RESET   = 1'b1;
   localparam logic [DW-1:0]   PERF_RESET  = 64'h0000_0000_0000_0000;
   localparam logic [3:0]      COUNTER1_SELECT_FLOW   = 4'h8;
   localparam logic [3:0]      COUNTER2_SELECT_PCMISS = 4'h2;
   localparam logic [3:0]      COUNTER2_SELECT_BRMISS = 4'h3;

   // ==========================================================
   // priority levels
   localparam int          NLVL      = 32;
   localparam logic [4:0]  LVL_TRAP  = 5'h02;
   localparam logic [4:0]  LVL_EXT0  = 5'h14;
   localparam logic [4:0]  LVL_PERF  = 5'h1D;
   localparam logic [4:0]  LVL_PFL   = 5'h1E;
   localparam logic [4:0]  LVL_MCK   = 5'h1F;
   localparam logic [4:0]  LVL_CRD   = 5'h1F;
   localparam logic [4:0]  LVL_SLI   = 5'h14;

   typedef enum logic [1:0] {
      ISUM_FLOW_JSR  = 2'b00,
      ISUM_FLOW_COND = 2'b01,
      ISUM_FLOW_ALL  = 2'b10
   } isum_flow_t;

endpackage

// *** core/isum_sync.sv ***
/*
 * two flip-flop synchroniser for a group of pin levels.
 * assumes inputs come from outside the sys_clk domain.
 */
`timescale 1ns/1ps
module isum_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] level_ff;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_ff  <= '0;
         level_ff <= '0;
      end else begin
         meta_ff  <= pin;
         level_ff <= meta_ff;
      end
   end

   assign level = level_ff;
endmodule

// *** core/isum_flag.sv ***
/*
 * sticky request flags: set by a pulse, dropped by a clear pulse.
 * assumes set and clear come from logic on sys_clk.
 */
`timescale 1ns/1ps
module isum_flag #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] q
);
   logic [W-1:0] q_ff;

   // set beats clear so an event in the clearing cycle survives
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         q_ff <= '0;
      end else begin
         q_ff <= (q_ff & ~clr) | set;
      end
   end

   assign q = q_ff;

   set_wins_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (set != '0) |=> ((q_ff & $past(set)) == $past(set)))
      else $error("flag set lost against clear");
endmodule

// *** core/isum_top.sv ***
/*
 * interrupt request bookkeeping and software-timed serial line.
 * summary of pending requests, clear register for edge requests,
 * software requests, trap bits, priority compare, serial pins.
 * assumes a 64-bit classic wishbone master on sys_clk; pins are
 * asynchronous; event pulses come from logic on sys_clk.
 */
`timescale 1ns/1ps
module isum_top
   import isum_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [AW-1:0] wb_adr_i,
   input  wire logic [SW-1:0] wb_sel_i,
   input  wire logic [DW-1:0] wb_dat_i,
   output logic      [DW-1:0] wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic [3:0]    ext_irq_pin,
   input  wire logic          power_fail_pin,
   input  wire logic          machine_check_pin,
   input  wire logic          halt_pin,
   input  wire logic          serial_data_pin,
   input  wire logic [2:0]    perf_event,
   input  wire logic          corrected_error_event,
   input  wire logic [1:0]    cur_mode,
   input  wire logic          cache_load_active,
   input  wire logic          cache_load_clk,
   output logic               serial_clk,
   output logic               take_interrupt,
   output logic [DW-1:0]      perf_control,
   output isum_flow_t         ctr1_flow_sel
);
   // ==========================================================
   // bus slave
   logic          ack_ff;
   logic [DW-1:0] rdat_ff;
   logic          req;
   logic          wr_commit;
   logic [IW-1:0] idx;
   logic [DW-1:0] lane_mask;
   logic [DW-1:0] wdat;
   logic [DW-1:0] nxt_rdat;

   assign req       = wb_cyc_i & wb_stb_i;
   assign idx       = wb_adr_i[IDX_HI:IDX_LO];
   // writes land at the edge where the master sees ack
   assign wr_commit = req & ack_ff & wb_we_i;

   for (genvar b = 0; b < SW; b++) begin : g_lane
      assign lane_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
   end
   assign wdat = wb_dat_i & lane_mask;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdat_ff <= '0;
      end else if (req & ~ack_ff) begin
         rdat_ff <= nxt_rdat;
      end
   end

   assign wb_ack_o = ack_ff & req;
   assign wb_dat_o = rdat_ff;

   // ==========================================================
   // pin synchronisers
   logic [3:0] ext_lvl;
   logic [3:0] misc_lvl;
   logic       pfl_lvl;
   logic       mck_lvl;
   logic       hlt_lvl;
   logic       rx_lvl;

   isum_sync #(.W(4)) u_sync_ext (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin     (ext_irq_pin),
      .level   (ext_lvl)
   );

   isum_sync #(.W(4)) u_sync_misc (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pin     ({power_fail_pin, machine_check_pin, halt_pin, serial_data_pin}),
      .level   (misc_lvl)
   );

   assign {pfl_lvl, mck_lvl, hlt_lvl, rx_lvl} = misc_lvl;

   // ==========================================================
   // software-owned registers
   logic [15:1]    software_interrupt_request_ff;
   logic [TRAP_HI:0] trap_req_ff;
   logic [TRAP_HI:0] trap_en_ff;
   logic [IPL_HI:0]  ipl_ff;
   logic           sle_ff;
   logic           tmt_ff;
   logic [DW-1:0]  perf_ff;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         software_interrupt_request_ff <= '0;
      end else if (wr_commit && idx == IDX_SOFTWARE_INTERRUPT_REQUEST) begin
         software_interrupt_request_ff <= wdat[SWR_HI:SWR_LO] | (software_interrupt_request_ff & ~lane_mask[SWR_HI:SWR_LO]);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         trap_req_ff <= '0;
         trap_en_ff  <= '0;
      end else if (wr_commit && idx == IDX_TRAP_REQ && wb_sel_i[0]) begin
         trap_req_ff <= wdat[TRAP_HI:0];
      end else if (wr_commit && idx == IDX_TRAP_EN && wb_sel_i[0]) begin
         trap_en_ff <= wdat[TRAP_HI:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ipl_ff <= '0;
      end else if (wr_commit && idx == IDX_IPL && wb_sel_i[0]) begin
         ipl_ff <= wdat[IPL_HI:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sle_ff <= 1'b0;
      end else if (wr_commit && idx == IDX_IUCTL && wb_sel_i[SLE_BIT/8]) begin
         sle_ff <= wdat[SLE_BIT];
      end
   end

   // transmit bit idles high; software loops pace every bit
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tmt_ff <= TMT_RESET;
      end else if (wr_commit && idx == IDX_XMIT && wb_sel_i[0]) begin
         tmt_ff <= wdat[TMT_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         perf_ff <= PERF_RESET;
      end else if (wr_commit && idx == IDX_PERF) begin
         perf_ff <= wdat | (perf_ff & ~lane_mask);
      end
   end

   assign perf_control = perf_ff;

   // select 8 on counter 1 is read through counter 2's select
   always_comb begin
      if (perf_ff[COUNTER2_SELECT_HI:COUNTER2_SELECT_LO] == COUNTER2_SELECT_PCMISS) begin
         ctr1_flow_sel = ISUM_FLOW_JSR;
      end else if (perf_ff[COUNTER2_SELECT_HI:COUNTER2_SELECT_LO] == COUNTER2_SELECT_BRMISS) begin
         ctr1_flow_sel = ISUM_FLOW_COND;
      end else begin
         ctr1_flow_sel = ISUM_FLOW_ALL;
      end
   end

   // ==========================================================
   // shared serial pins
   // the loader owns the clock pin while active; software must not
   // toggle the transmit bit then, the pin would not show it anyway
   assign serial_clk = cache_load_active ? cache_load_clk : tmt_ff;

   logic rx_prev_ff;
   logic rx_edge;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_prev_ff <= 1'b0;
      end else begin
         rx_prev_ff <= rx_lvl;
      end
   end

   // loader data toggles are not serial line traffic
   assign rx_edge = (rx_lvl ^ rx_prev_ff) & ~cache_load_active;

   // ==========================================================
   // edge-sensitive request flags
   logic       clr_hit;
   logic [4:0] flag_set;
   logic [4:0] flag_clr;
   logic [4:0] flag_q;
   logic [2:0] perf_pend;
   logic       crd_pend;
   logic       sli_pend;

   assign clr_hit  = wr_commit && idx == IDX_HWCLR;
   assign flag_set = {rx_edge & sle_ff,
                      corrected_error_event, perf_event};
   assign flag_clr = {5{clr_hit}} & {wdat[SLI_BIT],
                      wdat[CRD_BIT],
                      wdat[PERF_HI:PERF_LO]};

   isum_flag #(.W(5)) u_flags (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .set     (flag_set),
      .clr     (flag_clr),
      .q       (flag_q)
   );

   assign {sli_pend, crd_pend, perf_pend} = flag_q;

   // ==========================================================
   // summary
   logic [TRAP_HI:0] trap_live;
   logic [TRAP_HI:0] mode_ok;
   logic             trap_hit;
   logic [SUM_HI:0]  summary;

   assign trap_live = trap_req_ff & trap_en_ff;

   // request bit i belongs to mode code i; smaller code ranks higher
   for (genvar m = 0; m <= TRAP_HI; m++) begin : g_mode
      assign mode_ok[m] = cur_mode <= 2'(m);
   end
   assign trap_hit = |(trap_live & mode_ok);

   always_comb begin
      summary                   = '0;
      summary[TRAP_HI:0]        = trap_live;
      summary[SWR_HI:SWR_LO]    = software_interrupt_request_ff;
      summary[TRAP_PEND]        = trap_hit;
      summary[EXT_HI:EXT_LO]    = ext_lvl;
      summary[PERF_HI:PERF_LO]  = perf_pend;
      summary[PFL_BIT]          = pfl_lvl;
      summary[MCK_BIT]          = mck_lvl;
      summary[CRD_BIT]          = crd_pend;
      summary[SLI_BIT]          = sli_pend;
      summary[HLT_BIT]          = hlt_lvl;
   end

   // ==========================================================
   // priority compare
   logic [NLVL-1:0] lvl_pend;
   logic [NLVL-1:0] lvl_above;
   logic            take_ff;

   always_comb begin
      lvl_pend           = '0;
      lvl_pend[15:1]     = software_interrupt_request_ff;
      lvl_pend[LVL_TRAP] = trap_hit;
      for (int e = 0; e < 4; e++) begin
         lvl_pend[LVL_EXT0 + 5'(e)] = lvl_pend[LVL_EXT0 + 5'(e)] | ext_lvl[e];
      end
      lvl_pend[LVL_SLI]  = lvl_pend[LVL_SLI] | sli_pend;
      lvl_pend[LVL_PERF] = |perf_pend;
      lvl_pend[LVL_PFL]  = pfl_lvl;
      lvl_pend[LVL_MCK]  = mck_lvl | crd_pend;
   end

   for (genvar l = 0; l < NLVL; l++) begin : g_above
      assign lvl_above[l] = 5'(l) > ipl_ff;
   end

   // halt has no level and is never masked
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         take_ff <= 1'b0;
      end else begin
         take_ff <= |(lvl_pend & lvl_above) | hlt_lvl;
      end
   end

   assign take_interrupt = take_ff;

   // ==========================================================
   // read mux
   always_comb begin
      nxt_rdat = '0;
      case (idx)
         IDX_SUMMARY:  nxt_rdat[SUM_HI:0]        = summary;
         IDX_SOFTWARE_INTERRUPT_REQUEST:     nxt_rdat[SWR_HI:SWR_LO]   = software_interrupt_request_ff;
         IDX_TRAP_REQ: nxt_rdat[TRAP_HI:0]       = trap_req_ff;
         IDX_TRAP_EN:  nxt_rdat[TRAP_HI:0]       = trap_en_ff;
         IDX_IUCTL:    nxt_rdat[SLE_BIT]         = sle_ff;
         IDX_IPL:      nxt_rdat[IPL_HI:0]        = ipl_ff;
         IDX_RCV:      nxt_rdat[RCV_BIT]         = rx_lvl;
         IDX_PERF:     nxt_rdat                  = perf_ff;
         IDX_HWCLR:    nxt_rdat                  = '0;
         default:      nxt_rdat                  = '0;
      endcase
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   ack_single_pulse_a: assert property (
      ack_ff |=> !ack_ff)
      else $error("ack held longer than one cycle");

   perf_clear_a: assert property (
      (clr_hit && wdat[PERF_LO] && !perf_event[0]) |=> !perf_pend[0])
      else $error("counter 0 request not dropped");

   crd_clear_a: assert property (
      (clr_hit && wdat[CRD_BIT] && !corrected_error_event) |=> !crd_pend)
      else $error("corrected error request not dropped");

   sli_clear_a: assert property (
      (clr_hit && wdat[SLI_BIT] && !flag_set[4]) |=> !sli_pend)
      else $error("serial request not dropped");

   trap_read_a: assert property (
      (req && !ack_ff && !wb_we_i && idx == IDX_SUMMARY) |=>
      (wb_dat_o[TRAP_HI:0] == $past(trap_req_ff & trap_en_ff)))
      else $error("summary trap bits wrong");

   tx_pin_a: assert property (
      (wr_commit && idx == IDX_XMIT && wb_sel_i[0]) ##1 !cache_load_active |->
      serial_clk == $past(wb_dat_i[TMT_BIT]))
      else $error("serial clock pin not following transmit bit");

   rx_edge_a: assert property (
      (rx_lvl != rx_prev_ff && sle_ff && !cache_load_active) |=> sli_pend)
      else $error("serial data transition not latched");

   sli_gate_a: assert property (
      (!sle_ff && !sli_pend) |=> !sli_pend)
      else $error("serial request without enable");

   ipl_mask_a: assert property (
      (ipl_ff == 5'h1F && !hlt_lvl) |=> !take_ff)
      else $error("interrupt taken at top priority level");
endmodule

// *** dv/isum_peer.sv ***
/*
 * far-side model: external interrupt sources, serial line peer and
 * cache loader sharing the serial pins.
 * assumes the bench calls its tasks; every change lands on a rising edge.
 */
`timescale 1ns/1ps
module isum_peer (
   input  wire logic       sys_clk,
   output logic      [3:0] ext_irq_pin,
   output logic            power_fail_pin,
   output logic            machine_check_pin,
   output logic            halt_pin,
   output logic            serial_data_pin,
   output logic      [2:0] perf_event,
   output logic            corrected_error_event,
   output logic            cache_load_active,
   output logic            cache_load_clk
);
   initial begin
      {ext_irq_pin, power_fail_pin, machine_check_pin, halt_pin} = 7'h00;
      serial_data_pin       = 1'b1;
      perf_event            = 3'h0;
      corrected_error_event = 1'b0;
      cache_load_active     = 1'b0;
      cache_load_clk        = 1'b0;
   end
   // ==========================================================
   // level and pulse sources
   task automatic set_lines(input logic [3:0] irq, input logic pf, mc, ht);
      @(posedge sys_clk);
      {ext_irq_pin, power_fail_pin, machine_check_pin, halt_pin} <= {irq, pf, mc, ht};
   endtask
   task automatic pulse_events(input logic [2:0] pe, input logic ce);
      @(posedge sys_clk);
      perf_event            <= pe;
      corrected_error_event <= ce;
      @(posedge sys_clk);
      perf_event            <= 3'h0;
      corrected_error_event <= 1'b0;
   endtask
   // ==========================================================
   // shared serial pins
   task automatic serial_level(input logic b);
      @(posedge sys_clk);
      serial_data_pin <= b;
   endtask
   task automatic loader(input logic act, input logic clk);
      @(posedge sys_clk);
      // loader clock only while it owns the pins, never overlapping
      cache_load_active <= act;
      cache_load_clk    <= act & clk;
   endtask
endmodule

// *** dv/tb_top.sv ***
/*
 * self-checking bench for the interrupt summary and serial line block.
 * assumes isum_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
module tb_top
   import isum_pkg::*;
;
   localparam logic [DW-1:0] ALL = '1;
   logic            sys_clk;
   logic            sys_rst = 1'b1;
   logic            wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [AW-1:0]   wb_adr_i = '0;
   logic [SW-1:0]   wb_sel_i = '0;
   logic [DW-1:0]   wb_dat_i = '0, wb_dat_o, perf_control, rd_data, d;
   logic            wb_ack_o, serial_clk, take_interrupt;
   logic [1:0]      cur_mode = 2'h0;
   isum_flow_t      ctr1_flow_sel;
   logic [3:0]      ext_irq_pin;
   logic            power_fail_pin, machine_check_pin, halt_pin, serial_data_pin;
   logic [2:0]      perf_event;
   logic            corrected_error_event, cache_load_active, cache_load_clk;
   int              num_errors = 0, tests_run = 0;
   logic [DW-1:0]   txd [3] = '{64'h0, 64'hFFFF_FFFF_FFFF_FF7F, 64'h80};
   logic [3:0]      counter2_select [3] = '{4'h2, 4'h3, 4'h5};
   isum_flow_t      flow [3] = '{ISUM_FLOW_JSR, ISUM_FLOW_COND, ISUM_FLOW_ALL};

   isum_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .ext_irq_pin(ext_irq_pin), .power_fail_pin(power_fail_pin),
      .machine_check_pin(machine_check_pin), .halt_pin(halt_pin),
      .serial_data_pin(serial_data_pin), .perf_event(perf_event),
      .corrected_error_event(corrected_error_event), .cur_mode(cur_mode),
      .cache_load_active(cache_load_active), .cache_load_clk(cache_load_clk),
      .serial_clk(serial_clk), .take_interrupt(take_interrupt),
      .perf_control(perf_control), .ctr1_flow_sel(ctr1_flow_sel));
   isum_peer u_peer (.sys_clk(sys_clk), .ext_irq_pin(ext_irq_pin),
      .power_fail_pin(power_fail_pin), .machine_check_pin(machine_check_pin),
      .halt_pin(halt_pin), .serial_data_pin(serial_data_pin), .perf_event(perf_event),
      .corrected_error_event(corrected_error_event),
      .cache_load_active(cache_load_active), .cache_load_clk(cache_load_clk));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // ==========================================================
   // checking and bus tasks
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one classic cycle; request held until ack is sampled high
   task automatic wb_xfer(input logic we, input logic [IW-1:0] idx, input logic [SW-1:0] sel,
                          input logic [DW-1:0] wd);
      int n;
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      wb_adr_i <= {idx, 3'h0};
      wb_sel_i <= sel;
      wb_dat_i <= wd;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         num_errors++;
         $display("[FAIL] bus ack expected 1 seen %b", wb_ack_o);
         complete_run();
      end
      rd_data = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task automatic wr(input logic [IW-1:0] idx, input logic [DW-1:0] wd);
      wb_xfer(1'b1, idx, 8'hFF, wd);
   endtask
   task automatic rdc(input string what, input logic [IW-1:0] idx, input logic [DW-1:0] m, e);
      wb_xfer(1'b0, idx, 8'hFF, '0);
      chk(what, e & m, rd_data & m);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      settle(1);
      chk("tmt_reset", 64'h1, 64'(serial_clk));
      chk("flow_reset", 64'(ISUM_FLOW_ALL), 64'(ctr1_flow_sel));
      rdc("summary_reset", IDX_SUMMARY, ALL, '0);
      rdc("clear_read", IDX_HWCLR, ALL, '0);
      rdc("unmapped", 9'h1FF, ALL, '0);
      rdc("sle_reset", IDX_IUCTL, 64'h2_0000_0000, '0);
      $display("test reset done");
      wr(IDX_SOFTWARE_INTERRUPT_REQUEST, 64'h7FFF0);
      wr(IDX_SUMMARY, ALL);
      rdc("sw_summary", IDX_SUMMARY, ALL, 64'h7FFF0);
      wr(IDX_IPL, 64'hF);
      settle(3);
      chk("take_equal", '0, 64'(take_interrupt));
      wr(IDX_IPL, 64'hE);
      settle(3);
      chk("take_above", 64'h1, 64'(take_interrupt));
      wr(IDX_SOFTWARE_INTERRUPT_REQUEST, '0);
      wr(IDX_IPL, 64'h1F);
      $display("test software done");
      wr(IDX_TRAP_REQ, 64'hF);
      wr(IDX_TRAP_EN, 64'h5);
      for (int m = 0; m < 4; m++) begin
         @(posedge sys_clk);
         cur_mode <= 2'(m);
         d = 64'h5 | ((m <= 2) ? 64'h8_0000 : 64'h0);
         rdc("trap", IDX_SUMMARY, ALL, d);
      end
      wr(IDX_TRAP_REQ, '0);
      $display("test trap done");
      u_peer.pulse_events(3'h7, 1'b1);
      rdc("events", IDX_SUMMARY, ALL, 64'h1_3800_0000);
      wr(IDX_HWCLR, '0);
      rdc("clear_zero", IDX_SUMMARY, ALL, 64'h1_3800_0000);
      wr(IDX_HWCLR, 64'h1000_0000);
      rdc("clear_one", IDX_SUMMARY, ALL, 64'h1_2800_0000);
      wb_xfer(1'b1, IDX_HWCLR, 8'h08, 64'h1_2800_0000);
      rdc("clear_lane", IDX_SUMMARY, ALL, 64'h1_0000_0000);
      wr(IDX_IPL, 64'h1E);
      settle(3);
      chk("take_crd", 64'h1, 64'(take_interrupt));
      wr(IDX_HWCLR, 64'h1_0000_0000);
      rdc("clear_crd", IDX_SUMMARY, ALL, '0);
      settle(0);
      chk("take_none", '0, 64'(take_interrupt));
      wr(IDX_IPL, 64'h1C);
      u_peer.pulse_events(3'h4, 1'b0);
      settle(3);
      chk("take_perf", 64'h1, 64'(take_interrupt));
      wr(IDX_IPL, 64'h1D);
      settle(3);
      chk("mask_perf", '0, 64'(take_interrupt));
      wr(IDX_HWCLR, 64'h2000_0000);
      rdc("clear_perf2", IDX_SUMMARY, ALL, '0);
      wr(IDX_IPL, 64'h1F);
      $display("test events done");
      u_peer.set_lines(4'hA, 1'b1, 1'b1, 1'b1);
      settle(5);
      rdc("pins", IDX_SUMMARY, ALL, 64'h4_C0A0_0000);
      chk("take_halt", 64'h1, 64'(take_interrupt));
      u_peer.set_lines(4'h0, 1'b0, 1'b0, 1'b0);
      settle(5);
      rdc("pins_gone", IDX_SUMMARY, ALL, '0);
      $display("test pins done");
      u_peer.serial_level(1'b0);
      settle(5);
      rdc("rcv_low", IDX_RCV, 64'h40, '0);
      rdc("sli_off", IDX_SUMMARY, ALL, '0);
      wr(IDX_IUCTL, 64'h2_0000_0000);
      u_peer.serial_level(1'b1);
      settle(5);
      rdc("rcv_high", IDX_RCV, 64'h40, 64'h40);
      rdc("sli_on", IDX_SUMMARY, ALL, 64'h2_0000_0000);
      wr(IDX_HWCLR, 64'h2_0000_0000);
      rdc("sli_clear", IDX_SUMMARY, ALL, '0);
      u_peer.serial_level(1'b0);
      settle(5);
      rdc("sli_fall", IDX_SUMMARY, ALL, 64'h2_0000_0000);
      wr(IDX_HWCLR, 64'h2_0000_0000);
      u_peer.loader(1'b1, 1'b1);
      settle(0);
      chk("loader_clk_hi", 64'h1, 64'(serial_clk));
      u_peer.loader(1'b1, 1'b0);
      settle(0);
      chk("loader_clk_lo", '0, 64'(serial_clk));
      u_peer.serial_level(1'b1);
      settle(5);
      rdc("loader_data", IDX_SUMMARY, ALL, '0);
      u_peer.loader(1'b0, 1'b0);
      settle(0);
      chk("tmt_back", 64'h1, 64'(serial_clk));
      $display("test serial done");
      for (int i = 0; i < 3; i++) begin
         wr(IDX_XMIT, txd[i]);
         settle(0);
         chk("tmt", {63'h0, txd[i][TMT_BIT]}, 64'(serial_clk));
      end
      rdc("xmit_read", IDX_XMIT, ALL, '0);
      $display("test transmit done");
      for (int i = 0; i < 3; i++) begin
         d = {56'h0, COUNTER1_SELECT_FLOW, counter2_select[i]};
         wr(IDX_PERF, d);
         settle(0);
         chk("perf_copy", d, perf_control);
         chk("flow", 64'(flow[i]), 64'(ctr1_flow_sel));
         rdc("perf_read", IDX_PERF, ALL, d);
      end
      $display("test perf done");
      complete_run();
   end
endmodule
